// ==== logic/hssh_core.sv ====
// host system service handler: service interpreter, frame end path and axi4-lite registers
`timescale 1ns/1ps
`include "hssh_params.svh"

// Contract
// RULE_01: status reply carries five supply/oscillator ok flags
// RULE_02: status reply carries the thermal warning flag
// RULE_03: status bits 1:0 give the operating mode
// RULE_04: warn pin low on bad supply or heat
// RULE_05: stop request enters stop, then confirms
// RULE_06: exit goes to sync, ack on reaching normal
// RULE_07: all three features off after reset
// RULE_08: features take effect when idle or not normal
// RULE_09: a one enables, a zero changes nothing
// RULE_10: all-zero configure request just reports configuration
// RULE_11: auto polling fills own poll slot
// RULE_12: crc feature appends two crc bytes
// RULE_13: frame end by silence or end marker
// RULE_14: register write takes address then data byte
// RULE_15: register read returns addressed byte next
// RULE_16: host issues register access only when quiet
// RULE_17: host stops device before spi register write
// RULE_18: host reads registers only in stop states
// RULE_19: reply only after the whole request arrived
module hssh_core #(
  parameter int GAP_CYCLES = `HSSH_GAP_CYCLES
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output      logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output      logic        wready,
  output      logic [1:0]  bresp,
  output      logic        bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output      logic        arready,
  output      logic [31:0] rdata,
  output      logic [1:0]  rresp,
  output      logic        rvalid,
  input  wire logic        rready,
  // monitor pins
  input  wire logic        linear_reg_ok,
  input  wire logic        aux_regulator_ok,
  input  wire logic        bus_voltage_ok,
  input  wire logic        tank_cap_ok,
  input  wire logic        crystal_ok,
  input  wire logic        thermal_warning,
  output      logic        power_fail_warn_n,
  // bus side state
  input  wire logic        bus_idle,
  input  wire logic        busy_mode_active,
  input  wire logic        auto_ack_active,
  // host link receive
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  output      logic        rx_ready,
  // host link transmit
  output      logic        tx_valid,
  output      logic [7:0]  tx_data,
  input  wire logic        tx_ready,
  // frames forwarded to the host
  input  wire logic        fwd_valid,
  input  wire logic [7:0]  fwd_data,
  input  wire logic        fwd_last,
  input  wire logic [7:0]  fwd_result,
  output      logic        fwd_ready,
  // feature and mode outputs
  output      logic [1:0]  mode_state,
  output      logic        auto_poll_enable,
  output      logic        crc_enable,
  output      logic        marker_enable
);

  hssh_pkg::hssh_state_type s;
  hssh_pkg::hssh_state_type next_s;

  // mapped address check shared by read and write
  function automatic logic hssh_mapped(input logic [7:0] a);
    return a == `HSSH_ADDR_STATUS || a == `HSSH_ADDR_FEATURES || a == `HSSH_ADDR_CONTROL ||
           (a[7:5] == 3'(`HSSH_ADDR_INTREG >> 5) && a[1:0] == 2'h0);
  endfunction

  // one byte of crc-16-ccitt, msb first
  function automatic logic [15:0] hssh_crc(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[15] ^ d[7 - i]) ? ({r[14:0], 1'b0} ^ `HSSH_CRC_POLY) : {r[14:0], 1'b0};
    end
    return r;
  endfunction

  // step after the frame's data and crc
  function automatic hssh_pkg::hssh_fend_type hssh_after(input logic [2:0] f);
    return f[`HSSH_FEAT_MARKER] ? hssh_pkg::FE_MARK : hssh_pkg::FE_GAP;
  endfunction

  logic [7:0] status_byte;
  logic [7:0] cfg_byte;
  logic       cfg_go;

  always_comb begin
    next_s = s;
    // status byte: five ok flags, thermal warning, mode
    status_byte = {s.mon, s.mode}; // see RULE_01 RULE_02 RULE_03
    cfg_byte = `HSSH_IND_CFG | {3'h0, busy_mode_active, auto_ack_active, s.feat}; // see RULE_10
    cfg_go = s.cfg_wait && (bus_idle || s.mode != hssh_pkg::MODE_NORMAL);

    // monitor pins through two flip-flops
    next_s.mon_meta = {linear_reg_ok, aux_regulator_ok, bus_voltage_ok, tank_cap_ok,
                       crystal_ok, thermal_warning};
    next_s.mon = s.mon_meta;
    next_s.save_n = (&status_byte[7:3]) & ~status_byte[2]; // see RULE_04

    // operating mode
    case (s.mode)
      hssh_pkg::MODE_POWER_UP: begin
        if (&s.mon[5:1]) begin
          next_s.mode = hssh_pkg::MODE_SYNC;
        end
      end
      hssh_pkg::MODE_SYNC: begin
        if (!(&s.mon[5:1])) begin
          next_s.mode = hssh_pkg::MODE_POWER_UP;
        end else if (bus_idle) begin
          next_s.mode = hssh_pkg::MODE_NORMAL;
          if (s.exit_wait) begin
            next_s.exit_wait = 1'b0;
            next_s.exit_ack = 1'b1; // see RULE_06
          end
        end
      end
      hssh_pkg::MODE_NORMAL: begin
        if (!(&s.mon[5:1])) begin
          next_s.mode = hssh_pkg::MODE_POWER_UP;
        end
      end
      hssh_pkg::MODE_STOP: begin
        next_s.mode = hssh_pkg::MODE_STOP;
      end
      default: begin
        next_s.mode = hssh_pkg::MODE_POWER_UP;
      end
    endcase

    // pending features go live only on an idle bus or outside normal
    if (cfg_go) begin // see RULE_08
      next_s.feat = s.feat | s.cfg_req; // see RULE_09
      next_s.cfg_req = 3'h0;
      next_s.cfg_wait = 1'b0;
      next_s.cfg_ind = 1'b1;
    end

    // host service bytes
    if (rx_valid && s.rx_ready) begin
      if (s.cmd_wdata) begin
        next_s.regs[s.wr_addr] = rx_data; // see RULE_14
        next_s.cmd_wdata = 1'b0;
      end else if (rx_data == `HSSH_CMD_SYS_STATUS) begin
        next_s.reply_pend = 1'b1;
        next_s.reply_byte = status_byte; // see RULE_01 RULE_19
      end else if (rx_data == `HSSH_CMD_STOP) begin
        next_s.mode = hssh_pkg::MODE_STOP; // see RULE_05
        next_s.exit_wait = 1'b0;
        next_s.stop_conf = 1'b1;
      end else if (rx_data == `HSSH_CMD_EXIT_STOP) begin
        if (s.mode == hssh_pkg::MODE_STOP) begin
          next_s.mode = hssh_pkg::MODE_SYNC; // see RULE_06
          next_s.exit_wait = 1'b1;
        end
      end else if ((rx_data & `HSSH_CMD_CFG_MASK) == `HSSH_CMD_CFG) begin
        next_s.cfg_req = next_s.cfg_req | rx_data[2:0]; // see RULE_09 RULE_10
        next_s.cfg_wait = 1'b1;
      end else if ((rx_data & `HSSH_CMD_REG_MASK) == `HSSH_CMD_REG_WR) begin
        next_s.cmd_wdata = 1'b1; // see RULE_14 RULE_19
        next_s.wr_addr = rx_data[2:0];
      end else if ((rx_data & `HSSH_CMD_REG_MASK) == `HSSH_CMD_REG_RD) begin
        next_s.reply_pend = 1'b1;
        next_s.reply_byte = s.regs[rx_data[2:0]]; // see RULE_15
      end
    end

    // frame bytes from the receive path
    if (fwd_valid && s.fwd_ready) begin
      next_s.fwd_have = 1'b1;
      next_s.fwd_byte = fwd_data;
      next_s.fwd_last = fwd_last;
      next_s.fwd_result = fwd_result;
    end

    // transmit toward the host
    if (s.tx_valid && tx_ready) begin
      next_s.tx_valid = 1'b0;
    end
    if (s.fend != hssh_pkg::FE_GAP) begin
      next_s.gap_cnt = 17'(GAP_CYCLES - 1);
    end
    if (s.fend == hssh_pkg::FE_GAP) begin
      // silence counts from the edge at which the last byte is taken
      if (s.tx_valid) begin
        next_s.gap_cnt = 17'(GAP_CYCLES - 1);
      end else if (s.gap_cnt == 17'h0) begin // see RULE_13
        next_s.fend = hssh_pkg::FE_NONE;
      end else begin
        next_s.gap_cnt = s.gap_cnt - 17'h1;
      end
    end else if (!s.tx_valid && !s.tx_pause) begin
      if (s.reply_pend) begin
        next_s.tx_valid = 1'b1;
        next_s.tx_data = s.reply_byte; // see RULE_15
        next_s.reply_pend = 1'b0;
      end else if (s.stop_conf && s.mode == hssh_pkg::MODE_STOP) begin
        next_s.tx_valid = 1'b1;
        next_s.tx_data = `HSSH_IND_STOP; // see RULE_05
        next_s.stop_conf = 1'b0;
      end else if (s.exit_ack) begin
        next_s.tx_valid = 1'b1;
        next_s.tx_data = `HSSH_IND_EXIT; // see RULE_06
        next_s.exit_ack = 1'b0;
      end else if (s.cfg_ind) begin
        next_s.tx_valid = 1'b1;
        next_s.tx_data = cfg_byte; // see RULE_08
        next_s.cfg_ind = cfg_go;
      end else begin
        case (s.fend)
          hssh_pkg::FE_CRC_HI: begin
            next_s.tx_valid = 1'b1;
            next_s.tx_data = s.crc[15:8]; // see RULE_12
            next_s.fend = hssh_pkg::FE_CRC_LO;
          end
          hssh_pkg::FE_CRC_LO: begin
            next_s.tx_valid = 1'b1;
            next_s.tx_data = s.crc[7:0];
            next_s.crc = `HSSH_CRC_INIT;
            next_s.fend = hssh_after(s.feat);
          end
          hssh_pkg::FE_MARK: begin
            next_s.tx_valid = 1'b1;
            next_s.tx_data = `HSSH_IND_FRAME_END; // see RULE_13
            next_s.fend = hssh_pkg::FE_RESULT;
          end
          hssh_pkg::FE_RESULT: begin
            next_s.tx_valid = 1'b1;
            next_s.tx_data = s.fwd_result;
            next_s.fend = hssh_pkg::FE_NONE;
          end
          default: begin
            if (s.fwd_have) begin
              next_s.tx_valid = 1'b1;
              next_s.tx_data = s.fwd_byte;
              if (!s.fwd_dup) begin
                next_s.crc = hssh_crc(s.crc, s.fwd_byte);
              end
              // a data byte equal to the end code goes out twice under the marker
              if (s.feat[`HSSH_FEAT_MARKER] && s.fwd_byte == `HSSH_IND_FRAME_END &&
                  !s.fwd_dup) begin
                next_s.fwd_dup = 1'b1;
              end else begin
                next_s.fwd_dup = 1'b0;
                next_s.fwd_have = 1'b0;
                if (s.fwd_last) begin
                  if (s.feat[`HSSH_FEAT_CRC]) begin
                    next_s.fend = hssh_pkg::FE_CRC_HI; // see RULE_12
                  end else begin
                    next_s.crc = `HSSH_CRC_INIT;
                    next_s.fend = hssh_after(s.feat); // see RULE_13
                  end
                end
              end
            end
          end
        endcase
      end
    end

    // axi4-lite write channel
    if (awvalid && s.awready) begin
      next_s.aw_have = 1'b1;
      next_s.awready = 1'b0;
      next_s.aw_addr = awaddr;
    end
    if (wvalid && s.wready) begin
      next_s.w_have = 1'b1;
      next_s.wready = 1'b0;
      next_s.w_data = wdata;
      next_s.w_strb = wstrb;
    end
    if (s.aw_have && s.w_have && !s.bvalid) begin
      next_s.aw_have = 1'b0;
      next_s.w_have = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = hssh_mapped(s.aw_addr) ? `HSSH_RESP_OKAY : `HSSH_RESP_SLVERR;
      if (s.w_strb[0]) begin
        if (s.aw_addr == `HSSH_ADDR_CONTROL) begin
          next_s.tx_pause = s.w_data[`HSSH_CTRL_TX_PAUSE];
        end else if (hssh_mapped(s.aw_addr) && s.aw_addr[7:5] == 3'(`HSSH_ADDR_INTREG >> 5)) begin
          next_s.regs[s.aw_addr[4:2]] = s.w_data[7:0];
        end
      end
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready = 1'b1;
    end

    // axi4-lite read channel
    if (arvalid && s.arready) begin
      next_s.arready = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rresp = hssh_mapped(araddr) ? `HSSH_RESP_OKAY : `HSSH_RESP_SLVERR;
      next_s.rdata = 32'h0000_0000;
      if (araddr == `HSSH_ADDR_STATUS) begin
        next_s.rdata = {24'h00_0000, status_byte};
      end else if (araddr == `HSSH_ADDR_FEATURES) begin
        next_s.rdata = {24'h00_0000, cfg_byte};
      end else if (araddr == `HSSH_ADDR_CONTROL) begin
        next_s.rdata = {31'h0000_0000, s.tx_pause};
      end else if (hssh_mapped(araddr)) begin
        next_s.rdata = {24'h00_0000, s.regs[araddr[4:2]]};
      end
    end
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end

    // ready for a new byte only with no reply waiting
    next_s.rx_ready = !next_s.reply_pend; // see RULE_19
    next_s.fwd_ready = !next_s.fwd_have;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
      s.rx_ready <= 1'b1;
      s.fwd_ready <= 1'b1;
      s.feat <= `HSSH_FEAT_RESET; // see RULE_07
      s.crc <= `HSSH_CRC_INIT;
      s.mode <= hssh_pkg::MODE_POWER_UP;
      s.fend <= hssh_pkg::FE_NONE;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign power_fail_warn_n = s.save_n;
  assign rx_ready = s.rx_ready;
  assign tx_valid = s.tx_valid;
  assign tx_data = s.tx_data;
  assign fwd_ready = s.fwd_ready;
  assign mode_state = s.mode;
  assign auto_poll_enable = s.feat[`HSSH_FEAT_POLL]; // see RULE_11
  assign crc_enable = s.feat[`HSSH_FEAT_CRC];
  assign marker_enable = s.feat[`HSSH_FEAT_MARKER];

endmodule

// ==== logic/hssh_params.svh ====
// offsets, field positions, reset values, service codes and timing counts
`ifndef HSSH_PARAMS_SVH
`define HSSH_PARAMS_SVH

// register byte addresses
`define HSSH_ADDR_STATUS    8'h00
`define HSSH_ADDR_FEATURES  8'h04
`define HSSH_ADDR_CONTROL   8'h08
`define HSSH_ADDR_INTREG    8'h20
`define HSSH_INTREG_COUNT   8
`define HSSH_INTREG_RESET   8'h00

// control register fields
`define HSSH_CTRL_TX_PAUSE  0

// feature bit positions inside the feature vector and the configure request
`define HSSH_FEAT_MARKER    0
`define HSSH_FEAT_CRC       1
`define HSSH_FEAT_POLL      2
`define HSSH_FEAT_RESET     3'h0

// host service codes
`define HSSH_CMD_SYS_STATUS 8'h01
`define HSSH_CMD_STOP       8'h02
`define HSSH_CMD_EXIT_STOP  8'h03
`define HSSH_CMD_CFG_MASK   8'hF8
`define HSSH_CMD_CFG        8'h10
`define HSSH_CMD_REG_MASK   8'hF8
`define HSSH_CMD_REG_WR     8'h20
`define HSSH_CMD_REG_RD     8'h28

// indication codes sent to the host
`define HSSH_IND_STOP       8'h41
`define HSSH_IND_EXIT       8'h42
`define HSSH_IND_CFG        8'h40
`define HSSH_IND_FRAME_END  8'hCB

// crc-16-ccitt
`define HSSH_CRC_INIT       16'hFFFF
`define HSSH_CRC_POLY       16'h1021

// axi responses
`define HSSH_RESP_OKAY      2'h0
`define HSSH_RESP_SLVERR    2'h2

// frame end silence
`define HSSH_CLK_MHZ        20
`define HSSH_GAP_US         2600
`define HSSH_GAP_CYCLES     (`HSSH_GAP_US * `HSSH_CLK_MHZ)

`endif

// ==== logic/hssh_pkg.sv ====
// types of the host system service handler
package hssh_pkg;

  typedef enum logic [1:0] {MODE_POWER_UP, MODE_SYNC, MODE_STOP, MODE_NORMAL} hssh_mode_type;

  typedef enum logic [2:0] {FE_NONE, FE_CRC_HI, FE_CRC_LO, FE_MARK, FE_RESULT, FE_GAP}
    hssh_fend_type;

  typedef struct packed {
    logic          awready;
    logic          wready;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          aw_have;
    logic          w_have;
    logic [7:0]    aw_addr;
    logic [31:0]   w_data;
    logic [3:0]    w_strb;
    logic          arready;
    logic          rvalid;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
    logic          tx_pause;
    logic [5:0]    mon_meta;
    logic [5:0]    mon;
    logic          save_n;
    hssh_mode_type mode;
    logic [2:0]    feat;
    logic [2:0]    cfg_req;
    logic          cfg_wait;
    logic          cmd_wdata;
    logic [2:0]    wr_addr;
    logic [7:0][7:0] regs;
    logic          rx_ready;
    logic          reply_pend;
    logic [7:0]    reply_byte;
    logic          stop_conf;
    logic          exit_wait;
    logic          exit_ack;
    logic          cfg_ind;
    logic          tx_valid;
    logic [7:0]    tx_data;
    logic          fwd_ready;
    logic          fwd_have;
    logic          fwd_last;
    logic          fwd_dup;
    logic [7:0]    fwd_byte;
    logic [7:0]    fwd_result;
    hssh_fend_type fend;
    logic [15:0]   crc;
    logic [16:0]   gap_cnt;
  } hssh_state_type;

endpackage

// ==== test/hssh_core_sva.sv ====
// concurrent checks on the ports of the host system service handler
`timescale 1ns/1ps
module hssh_core_sva (
  // clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // register bus
  input wire logic       awvalid,
  input wire logic       awready,
  input wire logic       wvalid,
  input wire logic       wready,
  input wire logic       bvalid,
  input wire logic       arvalid,
  input wire logic       arready,
  input wire logic       rvalid,
  // monitor pins and bus idle
  input wire logic       linear_reg_ok,
  input wire logic       aux_regulator_ok,
  input wire logic       bus_voltage_ok,
  input wire logic       tank_cap_ok,
  input wire logic       crystal_ok,
  input wire logic       thermal_warning,
  input wire logic       power_fail_warn_n,
  input wire logic       bus_idle,
  // host link
  input wire logic       rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic       rx_ready,
  input wire logic       tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic       tx_ready,
  // mode and features
  input wire logic [1:0] mode_state,
  input wire logic       auto_poll_enable,
  input wire logic       crc_enable,
  input wire logic       marker_enable
);
  logic [2:0] feat_v;
  logic [2:0] feat_q;
  logic       good;
  logic       rx_take;
  logic       wr_pend;
  assign feat_v = {auto_poll_enable, crc_enable, marker_enable};
  assign good = linear_reg_ok & aux_regulator_ok & bus_voltage_ok & tank_cap_ok & crystal_ok
                & !thermal_warning;
  assign rx_take = rx_valid & rx_ready;
  // data byte of a register write is not a service code
  always_ff @(posedge aclk) begin
    feat_q <= aresetn ? feat_v : 3'b000;
    if (!aresetn) wr_pend <= 1'b0;
    else if (rx_take) wr_pend <= !wr_pend && rx_data[7:3] == 5'b00100;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence read_code;
    rx_take && !wr_pend && rx_data[7:3] == 5'b00101;
  endsequence
  sequence write_code;
    rx_take && !wr_pend && rx_data[7:3] == 5'b00100;
  endsequence
  warn_high_a: assert property (good [*5] |-> power_fail_warn_n)
    else $error("warn pin low with healthy supplies");
  warn_low_a: assert property (!good [*5] |-> !power_fail_warn_n)
    else $error("warn pin high with a supply fault");
  feat_reset_a: assert property ($rose(aresetn) |-> feat_v == 3'b000)
    else $error("feature active right after reset");
  feat_keep_a: assert property ((feat_q & ~feat_v) == 3'b000)
    else $error("feature switched off without reset");
  feat_when_a: assert property ((feat_v & ~feat_q) != 3'b000 |->
    $past(bus_idle) || $past(mode_state) != 2'd3) else $error("feature activated on busy bus");
  stop_conf_a: assert property ($rose(mode_state == 2'd2) |->
    ##[0:60] (tx_valid && tx_data == 8'h41)) else $error("stop confirm missing");
  rd_reply_a: assert property (read_code |=> !rx_ready ##[1:60] (tx_valid && rx_ready))
    else $error("register read reply missing");
  wr_quiet_a: assert property (write_code |=> rx_ready [*2])
    else $error("reply started before data byte");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("link byte dropped before taken");
  wr_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write response late");
  rd_answer_a: assert property (arvalid && arready |-> ##[1:2] rvalid)
    else $error("read response late");
endmodule

bind hssh_core hssh_core_sva u_sva (.*);

// ==== test/hssh_host_model.sv ====
// host controller model on the byte link
`timescale 1ns/1ps
module hssh_host_model #(
  parameter bit SLOW = 1'b1
) (
  // clock
  input  wire logic       aclk,
  // host to device
  output      logic       rx_valid,
  output      logic [7:0] rx_data,
  input  wire logic       rx_ready,
  // device to host
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output      logic       tx_ready
);
  logic [7:0] got [$];
  int         at [$];
  int         cyc;
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b0;
    cyc      = 0;
  end
  // collects bytes and stalls at random
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    tx_ready <= SLOW ? 1'($urandom_range(1, 0)) : 1'b1;
    if (tx_valid && tx_ready) begin
      got.push_back(tx_data);
      at.push_back(cyc);
    end
  end
  task automatic send(input logic [7:0] b);
    @(posedge aclk);
    rx_valid <= 1'b1;
    rx_data  <= b;
    do @(posedge aclk); while (!rx_ready);
    rx_valid <= 1'b0;
    rx_data  <= ~b;
  endtask
endmodule

// ==== test/hssh_core_tb.sv ====
// self-checking bench of the host system service handler
`timescale 1ns/1ps
`include "hssh_params.svh"
module hssh_core_tb;
  localparam int GAP = 20;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, bus_idle = 1'b1, busy_mode_active, auto_ack_active;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, rx_data, tx_data;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, rx_valid, rx_ready, tx_valid, tx_ready;
  logic [1:0] bresp, rresp, mode_state;
  logic linear_reg_ok, aux_regulator_ok, bus_voltage_ok, tank_cap_ok, crystal_ok;
  logic thermal_warning, power_fail_warn_n, auto_poll_enable, crc_enable, marker_enable;
  logic fwd_valid = 1'b0, fwd_last = 1'b0, fwd_ready;
  logic [7:0] fwd_data = 8'h00, fwd_result = 8'h00;
  int n_mismatch = 0, tests_run = 0, mode_m, t_last, t_frame;
  logic [2:0] feat_m;
  logic [5:0] mon_m = 6'b11_1110;
  logic [7:0] regs_m [8];
  logic [7:0] exp_q [$];
  logic [7:0] frm [$];
  logic [31:0] rd_d;
  logic [1:0] rd_r;

  hssh_core #(.GAP_CYCLES(GAP)) u_dut (.*);
  hssh_host_model u_host (.aclk, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data, .tx_ready);

  assign {linear_reg_ok, aux_regulator_ok, bus_voltage_ok, tank_cap_ok, crystal_ok} = mon_m[5:1];
  assign thermal_warning = mon_m[0];

  initial forever #25 aclk = ~aclk;

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] status_m();
    return {mon_m, 2'(mode_m)};
  endfunction
  function automatic logic [7:0] cfg_m();
    return {3'b010, busy_mode_active, auto_ack_active, feat_m};
  endfunction
  // compare every expected link byte with what the host saw
  task automatic drain();
    int t;
    while (exp_q.size() > 0) begin
      t = 0;
      while (u_host.got.size() == 0 && t < 3000) begin
        @(posedge aclk);
        t++;
      end
      t_last = u_host.at.size() > 0 ? u_host.at.pop_front() : 0;
      chk_byte(u_host.got.size() > 0 ? u_host.got.pop_front() : 8'hxx, exp_q.pop_front());
    end
  endtask
  task automatic svc(input logic [7:0] b, input logic [7:0] e);
    u_host.send(b);
    exp_q.push_back(e);
    drain();
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    ta = 1'b0;
    tw = 1'b0;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (awready && !ta) awvalid <= 1'b0;
      if (wready && !tw) wvalid <= 1'b0;
      ta |= awready;
      tw |= wready;
    end
    do @(posedge aclk); while (!bvalid);
    rd_r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rd_d = rdata;
    rd_r = rresp;
    rready <= 1'b0;
  endtask
  task automatic reg_chk(input logic [7:0] a, input logic [31:0] e);
    axi_rd(a);
    chk_val(rd_d, e);
  endtask
  // forward one frame and predict the bytes the host must see
  task automatic frame();
    logic [15:0] c;
    c = `HSSH_CRC_INIT;
    foreach (frm[i]) begin
      @(posedge aclk);
      fwd_valid <= 1'b1;
      fwd_data <= frm[i];
      fwd_last <= (i == frm.size() - 1);
      fwd_result <= 8'h3c;
      do @(posedge aclk); while (!fwd_ready);
      fwd_valid <= 1'b0;
      fwd_data <= ~frm[i];
      exp_q.push_back(frm[i]);
      if (feat_m[0] && frm[i] == `HSSH_IND_FRAME_END) exp_q.push_back(frm[i]);
      c = c ^ {frm[i], 8'h00};
      repeat (8) c = c[15] ? (c << 1) ^ `HSSH_CRC_POLY : c << 1;
    end
    if (feat_m[1]) exp_q.push_back(c[15:8]);
    if (feat_m[1]) exp_q.push_back(c[7:0]);
    if (feat_m[0]) exp_q.push_back(`HSSH_IND_FRAME_END);
    if (feat_m[0]) exp_q.push_back(8'h3c);
    drain();
  endtask
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge aclk);
    n_mismatch++;
    close_out();
  end

  initial begin
    void'($urandom(65882));
    {busy_mode_active, auto_ack_active} = 2'($urandom);
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (10) @(posedge aclk);
    feat_m = 3'b000;
    chk_val(32'({auto_poll_enable, crc_enable, marker_enable}), 0);
    for (int i = 0; i < 7; i++) begin
      mon_m <= 6'b11_1110 ^ (6'b00_0001 << i);
      repeat (8) @(posedge aclk);
      mode_m = &mon_m[5:1] ? 3 : 0;
      chk_val(32'(power_fail_warn_n), 32'(&mon_m[5:1] & ~mon_m[0]));
      reg_chk(`HSSH_ADDR_STATUS, 32'(status_m()));
      svc(`HSSH_CMD_SYS_STATUS, status_m());
      mon_m <= 6'b11_1110;
      repeat (10) @(posedge aclk);
    end
    mode_m = 3;
    svc(`HSSH_CMD_CFG, cfg_m());
    bus_idle <= 1'b0;
    u_host.send(`HSSH_CMD_CFG | 8'h02);
    repeat (15) @(posedge aclk);
    chk_val(32'(crc_enable), 0);
    chk_val(32'(u_host.got.size()), 0);
    bus_idle <= 1'b1;
    feat_m = 3'b010;
    exp_q.push_back(cfg_m());
    drain();
    svc(`HSSH_CMD_CFG, cfg_m());
    frm = '{8'ha1, 8'hcb, 8'h05};
    frame();
    t_frame = t_last;
    svc(`HSSH_CMD_SYS_STATUS, status_m());
    chk_val(32'(t_last - t_frame >= GAP), 1);
    svc(`HSSH_CMD_STOP, `HSSH_IND_STOP);
    mode_m = 2;
    reg_chk(`HSSH_ADDR_STATUS, 32'(status_m()));
    bus_idle <= 1'b0;
    feat_m = 3'b111;
    svc(`HSSH_CMD_CFG | 8'h05, cfg_m());
    chk_val(32'(auto_poll_enable), 1);
    axi_wr(`HSSH_ADDR_CONTROL, 32'h0000_0001);
    reg_chk(`HSSH_ADDR_CONTROL, 1);
    reg_chk(`HSSH_ADDR_FEATURES, 32'(cfg_m()));
    u_host.send(`HSSH_CMD_SYS_STATUS);
    repeat (10) @(posedge aclk);
    chk_val(32'(u_host.got.size()), 0);
    axi_wr(`HSSH_ADDR_CONTROL, 32'h0000_0000);
    exp_q.push_back(status_m());
    drain();
    bus_idle <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      regs_m[a] = 8'($urandom);
      u_host.send(`HSSH_CMD_REG_WR | 8'(a));
      repeat (6) @(posedge aclk);
      chk_val(32'(u_host.got.size()), 0);
      u_host.send(regs_m[a]);
    end
    regs_m[3] = 8'($urandom);
    axi_wr(`HSSH_ADDR_INTREG + 8'd12, 32'(regs_m[3]));
    for (int a = 0; a < 8; a++) begin
      svc(`HSSH_CMD_REG_RD | 8'(a), regs_m[a]);
      reg_chk(`HSSH_ADDR_INTREG + 8'(4 * a), 32'(regs_m[a]));
    end
    reg_chk(8'h0c, 0);
    chk_val(32'(rd_r), 32'(`HSSH_RESP_SLVERR));
    axi_wr(8'h0c, $urandom);
    chk_val(32'(rd_r), 32'(`HSSH_RESP_SLVERR));
    svc(`HSSH_CMD_EXIT_STOP, `HSSH_IND_EXIT);
    mode_m = 3;
    chk_val(32'(mode_state), 3);
    frm = '{8'hcb, 8'h5a, 8'hcb};
    frame();
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (10) @(posedge aclk);
    feat_m = 3'b000;
    chk_val(32'({auto_poll_enable, crc_enable, marker_enable}), 0);
    svc(`HSSH_CMD_CFG, cfg_m());
    close_out();
  end
endmodule
